// [design/adcom_pkg.sv]
// Constants, types and shared helpers of the ADC output mode and test pattern register bank
// How it works
// - Output mode register at 0x02: current 7-5, termination 4, disable 3, lane mode 2-0.
// - Current code maps 000..111 to 3.5/4.0/4.5/-/3.0/2.5/2.1/1.75 mA; 011 unused.
// - Termination bit on turns termination on and doubles the selected drive current.
// - Output disable bit 1 suppresses lane_valid while lane_data keeps updating; 0 lets lane_valid follow conv_valid.
// - Lane codes 000/001/010 give two lanes at 16/14/12 bits; 011, 100 unused.
// - Lane codes 101/110/111 give one lane at 14/12/16 bits.
// - Bit 7 at 0x03 swaps conversion data for the test pattern.
// - Bits 5-0 at 0x03 are pattern bits 13 down to 8.
// - Bit 6 at 0x03 is stored and read back, but its value has no effect on the pattern.
// - All bits at 0x04 are pattern bits 7 down to 0.
// - Frame under low chip select: 16 rising edges, flag, 7 address, 8 data.
// - Flag low writes addressed register; flag high reads it out open-drain, unchanged.
// - Writing 1 to bit 7 at 0x00 clears all registers; bit self-clears.
package adcom_pkg;
   localparam int PAT_W = 14;
   localparam logic [6:0] ADDR_RESET = 7'h00;
   localparam logic [6:0] ADDR_OUT_MODE = 7'h02;
   localparam logic [6:0] ADDR_PAT_HIGH = 7'h03;
   localparam logic [6:0] ADDR_PAT_LOW = 7'h04;
   localparam int SWRST_BIT = 7;
   localparam int DCS_LSB = 5;
   localparam int TERM_BIT = 4;
   localparam int OFF_BIT = 3;
   localparam int LSS_LSB = 0;
   localparam int PAT_EN_BIT = 7;
   localparam int PAT_HI_W = 6;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   localparam logic [4:0] CNT_FLAG = 5'h00;
   localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
   localparam logic [4:0] CNT_LAST = 5'h0F;
   localparam logic [4:0] CNT_DONE = 5'h10;
   // Drive current in microamps
   localparam logic [13:0] CUR_3P5 = 14'h0DAC;
   localparam logic [13:0] CUR_4P0 = 14'h0FA0;
   localparam logic [13:0] CUR_4P5 = 14'h1194;
   localparam logic [13:0] CUR_3P0 = 14'h0BB8;
   localparam logic [13:0] CUR_2P5 = 14'h09C4;
   localparam logic [13:0] CUR_2P1 = 14'h0834;
   localparam logic [13:0] CUR_1P75 = 14'h06D6;
   localparam logic [4:0] SER_16 = 5'h10;
   localparam logic [4:0] SER_14 = 5'h0E;
   localparam logic [4:0] SER_12 = 5'h0C;

   typedef struct packed {
      logic [7:0] out_mode;
      logic [7:0] pat_high;
      logic [7:0] pat_low;
   } adcom_regs_t;

   localparam adcom_regs_t REGS_RESET = '{REG_RESET_VAL, REG_RESET_VAL, REG_RESET_VAL};

   typedef enum logic [1:0] {
      PH_CMD = 2'b00,
      PH_DATA = 2'b01,
      PH_DONE = 2'b11
   } adcom_phase_t;

   // Shared by the link shadow copy and the main register bank
   function automatic adcom_regs_t adcom_write(input adcom_regs_t r, input logic [6:0] a, input logic [7:0] d);
      adcom_regs_t n;
      n = r;
      case (a)
         ADDR_RESET: begin
            if (d[SWRST_BIT]) begin
               n = REGS_RESET;
            end
         end
         ADDR_OUT_MODE: n.out_mode = d;
         ADDR_PAT_HIGH: n.pat_high = d;
         ADDR_PAT_LOW: n.pat_low = d;
         default: n = r;
      endcase
      return n;
   endfunction : adcom_write

   function automatic logic [7:0] adcom_read(input adcom_regs_t r, input logic [6:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ADDR_OUT_MODE: v = r.out_mode;
         ADDR_PAT_HIGH: v = r.pat_high;
         ADDR_PAT_LOW: v = r.pat_low;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : adcom_read
endpackage : adcom_pkg

// [design/adcom_spi_link.sv]
// Serial programming link running on the serial clock
`timescale 1ns/1ps
module adcom_spi_link
   import adcom_pkg::*;
(
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo_oe,
   output logic wr_tgl,
   output logic [14:0] wr_word
);
   typedef struct packed {
      logic [4:0] cnt;
      adcom_phase_t phase;
      logic rw;
      logic [14:0] sh;
      logic [7:0] rd;
      logic sdo_oe;
   } adcom_frame_t;

   typedef struct packed {
      adcom_regs_t shadow;
      logic wr_tgl;
      logic [14:0] wr_word;
   } adcom_lstate_t;

   localparam adcom_frame_t FRAME_RESET = '{5'h00, PH_CMD, 1'b0, 15'h0000, 8'h00, 1'b0};
   localparam adcom_lstate_t LINK_RESET = '{REGS_RESET, 1'b0, 15'h0000};

   adcom_frame_t fr_q;
   adcom_frame_t fr_d;
   adcom_lstate_t ls_q;
   adcom_lstate_t ls_d;
   logic frame_rst;
   logic [14:0] word;

   // Serial clock stops between frames, so chip select ends each frame
   assign frame_rst = rst | cs_n;
   assign word = {fr_q.sh[13:0], sdi};

   always_comb begin
      fr_d = fr_q;
      ls_d = ls_q;
      if (fr_q.cnt != CNT_DONE) begin
         fr_d.cnt = fr_q.cnt + 5'h01;
         fr_d.sh = {fr_q.sh[13:0], sdi};
         if (fr_q.cnt == CNT_FLAG) begin
            fr_d.rw = sdi;
         end
         if (fr_q.cnt == CNT_ADDR_LAST) begin
            fr_d.phase = PH_DATA;
            if (fr_q.rw) begin
               fr_d.rd = adcom_read(ls_q.shadow, {fr_q.sh[5:0], sdi});
               fr_d.sdo_oe = ~fr_d.rd[7];
            end
         end else if (fr_q.cnt == CNT_LAST) begin
            fr_d.phase = PH_DONE;
            if (!fr_q.rw) begin
               ls_d.shadow = adcom_write(ls_q.shadow, word[14:8], word[7:0]);
               ls_d.wr_word = word;
               ls_d.wr_tgl = ~ls_q.wr_tgl;
            end
         end else if (fr_q.phase == PH_DATA && fr_q.rw) begin
            // Open drain: enable pulls low for a zero bit
            fr_d.rd = {fr_q.rd[6:0], 1'b0};
            fr_d.sdo_oe = ~fr_q.rd[6];
         end
      end
   end

   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         fr_q <= FRAME_RESET;
      end else begin
         fr_q <= fr_d;
      end
   end

   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         ls_q <= LINK_RESET;
      end else begin
         ls_q <= ls_d;
      end
   end

   assign sdo_oe = fr_q.sdo_oe;
   assign wr_tgl = ls_q.wr_tgl;
   assign wr_word = ls_q.wr_word;
endmodule : adcom_spi_link

// [design/adcom_output_mode.sv]
// Output mode and test pattern register bank with serial programming port
`timescale 1ns/1ps
module adcom_output_mode
   import adcom_pkg::*;
#(
   parameter int CH = 4,
   parameter int RES = 14
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo_i,
   output logic sdo_o,
   output logic sdo_oe,
   input wire logic [CH*RES-1:0] conv_data,
   input wire logic conv_valid,
   output logic [2:0] drive_current_select,
   output logic internal_termination_enable,
   output logic output_disable,
   output logic [2:0] lane_serialization_select,
   output logic pattern_enable,
   output logic [PAT_HI_W-1:0] pattern_high_bits,
   output logic [7:0] pattern_low_bits,
   output logic [13:0] drive_current_ua,
   output logic drive_code_valid,
   output logic two_lane,
   output logic [4:0] serial_bits,
   output logic lane_mode_valid,
   output logic [CH*RES-1:0] lane_data,
   output logic lane_valid
);
   if (RES != PAT_W || CH < 1) begin : g_check
      $error("adcom_output_mode: RES must be 14 and CH at least 1");
   end

   typedef struct packed {
      logic [2:0] wsync;
      adcom_regs_t regs;
      logic [13:0] drive_ua;
      logic drive_ok;
      logic two_lane;
      logic [4:0] ser_bits;
      logic lane_ok;
      logic [CH*RES-1:0] lane_data;
      logic lane_valid;
   } adcom_state_t;

   localparam adcom_state_t STATE_RESET = '{3'h0, REGS_RESET, 14'h0000, 1'b0, 1'b0, 5'h00, 1'b0, '0, 1'b0};

   adcom_state_t st_q;
   adcom_state_t st_d;
   logic wr_tgl;
   logic [14:0] wr_word;
   logic [2:0] dcs;
   logic [2:0] lss;
   logic [13:0] cur;
   logic [PAT_W-1:0] pattern;

   adcom_spi_link u_link (
      .rst(rst),
      .sck(sck),
      .cs_n(cs_n),
      .sdi(sdi),
      .sdo_oe(sdo_oe),
      .wr_tgl(wr_tgl),
      .wr_word(wr_word)
   );

   // Pin only ever pulls low; the device never senses its own pin
   assign sdo_o = 1'b0;

   assign dcs = st_q.regs.out_mode[DCS_LSB +: 3];
   assign lss = st_q.regs.out_mode[LSS_LSB +: 3];
   // Bit 6 of the high register is left out of the pattern
   assign pattern = {st_q.regs.pat_high[PAT_HI_W-1:0], st_q.regs.pat_low};

   always_comb begin
      st_d = st_q;
      // Toggle crossing; the word is stable long before the toggle lands
      st_d.wsync = {st_q.wsync[1:0], wr_tgl};
      if (st_q.wsync[2] != st_q.wsync[1]) begin
         st_d.regs = adcom_write(st_q.regs, wr_word[14:8], wr_word[7:0]);
      end
      cur = 14'h0000;
      st_d.drive_ok = 1'b1;
      case (dcs)
         3'h0: cur = CUR_3P5;
         3'h1: cur = CUR_4P0;
         3'h2: cur = CUR_4P5;
         3'h4: cur = CUR_3P0;
         3'h5: cur = CUR_2P5;
         3'h6: cur = CUR_2P1;
         3'h7: cur = CUR_1P75;
         default: st_d.drive_ok = 1'b0;
      endcase
      st_d.drive_ua = st_q.regs.out_mode[TERM_BIT] ? {cur[12:0], 1'b0} : cur;
      st_d.lane_ok = 1'b1;
      case (lss)
         3'h0: {st_d.two_lane, st_d.ser_bits} = {1'b1, SER_16};
         3'h1: {st_d.two_lane, st_d.ser_bits} = {1'b1, SER_14};
         3'h2: {st_d.two_lane, st_d.ser_bits} = {1'b1, SER_12};
         3'h5: {st_d.two_lane, st_d.ser_bits} = {1'b0, SER_14};
         3'h6: {st_d.two_lane, st_d.ser_bits} = {1'b0, SER_12};
         3'h7: {st_d.two_lane, st_d.ser_bits} = {1'b0, SER_16};
         default: begin
            {st_d.two_lane, st_d.ser_bits} = {1'b0, 5'h00};
            st_d.lane_ok = 1'b0;
         end
      endcase
      st_d.lane_valid = conv_valid & ~st_q.regs.out_mode[OFF_BIT];
      if (conv_valid) begin
         st_d.lane_data = st_q.regs.pat_high[PAT_EN_BIT] ? {CH{pattern}} : conv_data;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q <= STATE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign drive_current_select = dcs;
   assign internal_termination_enable = st_q.regs.out_mode[TERM_BIT];
   assign output_disable = st_q.regs.out_mode[OFF_BIT];
   assign lane_serialization_select = lss;
   assign pattern_enable = st_q.regs.pat_high[PAT_EN_BIT];
   assign pattern_high_bits = st_q.regs.pat_high[PAT_HI_W-1:0];
   assign pattern_low_bits = st_q.regs.pat_low;
   assign drive_current_ua = st_q.drive_ua;
   assign drive_code_valid = st_q.drive_ok;
   assign two_lane = st_q.two_lane;
   assign serial_bits = st_q.ser_bits;
   assign lane_mode_valid = st_q.lane_ok;
   assign lane_data = st_q.lane_data;
   assign lane_valid = st_q.lane_valid;
endmodule : adcom_output_mode

// [test/adcom_host.sv]
// Host model driving the serial programming link
`timescale 1ns/1ps
module adcom_host (
   output logic sck = 1'b0,
   output logic cs_n = 1'b1,
   output logic sdi = 1'b0,
   input wire logic sdo
);
   // Clock idles low outside frames; bits change just after each falling edge
   task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [15:0] w;
      w = {rw, a, d};
      q = 8'h00;
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi = w[i];
         #6;
         if (i < 8) q = {q[6:0], sdo};
         sck = 1'b1;
         #6;
         sck = 1'b0;
      end
      #6;
      cs_n = 1'b1;
      // Released line must not keep the last bit
      sdi = ~sdi;
      #30;
   endtask : xfer
endmodule : adcom_host

// [test/adcom_assertions.sv]
// Property checker for the output mode register bank
`timescale 1ns/1ps
module adcom_chk
   import adcom_pkg::*;
#(
   parameter int CH = 4,
   parameter int RES = 14
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sdo_o,
   input wire logic cs_n,
   input wire logic sdo_oe,
   input wire logic [CH*RES-1:0] conv_data,
   input wire logic conv_valid,
   input wire logic [2:0] drive_current_select,
   input wire logic internal_termination_enable,
   input wire logic output_disable,
   input wire logic [2:0] lane_serialization_select,
   input wire logic pattern_enable,
   input wire logic [PAT_HI_W-1:0] pattern_high_bits,
   input wire logic [7:0] pattern_low_bits,
   input wire logic [13:0] drive_current_ua,
   input wire logic drive_code_valid,
   input wire logic two_lane,
   input wire logic [4:0] serial_bits,
   input wire logic lane_mode_valid,
   input wire logic [CH*RES-1:0] lane_data,
   input wire logic lane_valid
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [13:0] pat;
   assign pat = {pattern_high_bits, pattern_low_bits};
   // Valid flag over microamps; unused code gives zero
   function automatic logic [14:0] cur_f(logic [2:0] c, logic t);
      logic [13:0] b;
      case (c)
         3'h0: b = 14'h0DAC;
         3'h1: b = 14'h0FA0;
         3'h2: b = 14'h1194;
         3'h4: b = 14'h0BB8;
         3'h5: b = 14'h09C4;
         3'h6: b = 14'h0834;
         3'h7: b = 14'h06D6;
         default: b = 14'h0000;
      endcase
      return {c != 3'h3, t ? {b[12:0], 1'b0} : b};
   endfunction : cur_f
   // Valid, two lanes, serialization width
   function automatic logic [6:0] lane_f(logic [2:0] c);
      case (c)
         3'h0: return 7'h70;
         3'h1: return 7'h6E;
         3'h2: return 7'h6C;
         3'h5: return 7'h4E;
         3'h6: return 7'h4C;
         3'h7: return 7'h50;
         default: return 7'h00;
      endcase
   endfunction : lane_f
   // Reset is still sampled high at its release edge, so that edge starts no attempt
   a_drive_map: assert property (!rst |=> {drive_code_valid, drive_current_ua} ==
      cur_f($past(drive_current_select), $past(internal_termination_enable))) else $error("drive map");
   a_lane_map: assert property (!rst |=> {lane_mode_valid, two_lane & lane_mode_valid, serial_bits} ==
      lane_f($past(lane_serialization_select))) else $error("lane map");
   a_lane_pulse: assert property (conv_valid && !output_disable |=> lane_valid) else $error("no pulse");
   a_lane_off: assert property (!conv_valid || output_disable |=> !lane_valid) else $error("stray pulse");
   a_pattern_sub: assert property (conv_valid && pattern_enable |=>
      lane_data == {CH{$past(pat)}}) else $error("pattern");
   a_conv_pass: assert property (conv_valid && !pattern_enable |=>
      lane_data == $past(conv_data)) else $error("pass data");
   a_lane_hold: assert property (!conv_valid |=> $stable(lane_data)) else $error("data moved");
   a_sdo_drain: assert property (sdo_o == 1'b0) else $error("sdo drive");
   // Link side: the pin must be released before the next frame begins
   a_sdo_release: assert property (@(negedge cs_n) !sdo_oe) else $error("sdo held");
   c_pattern: cover property (conv_valid && pattern_enable);
   c_disabled: cover property (conv_valid && output_disable);
   c_bad_code: cover property (drive_current_select == 3'h3);
endmodule : adcom_chk
bind adcom_output_mode adcom_chk #(.CH(CH), .RES(RES)) u_chk (.clock, .rst, .sdo_o, .cs_n, .sdo_oe,
   .conv_data, .conv_valid,
   .drive_current_select, .internal_termination_enable, .output_disable, .lane_serialization_select,
   .pattern_enable, .pattern_high_bits, .pattern_low_bits, .drive_current_ua, .drive_code_valid, .two_lane,
   .serial_bits, .lane_mode_valid, .lane_data, .lane_valid);

// [test/tb.sv]
// Self-checking bench of the output mode register bank
`timescale 1ns/1ps
module tb;
   import adcom_pkg::*;
   localparam logic [55:0] D = 56'h0123456789ABCD;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic conv_valid = 1'b0;
   logic [55:0] conv_data = 56'h0;
   logic sck, cs_n, sdi, sdo_o, sdo_oe, term, off, pen, lv;
   logic [2:0] dcs, lss;
   logic [5:0] phi;
   logic [7:0] plo;
   logic [55:0] ld;
   // Pull-up on the open-drain line
   wire sdo = sdo_oe ? sdo_o : 1'b1;
   int bad_count = 0;
   int n_tests = 0;
   always #50 clock = ~clock;
   adcom_host h (.sck, .cs_n, .sdi, .sdo);
   adcom_output_mode uut (.clock, .rst, .sck, .cs_n, .sdi, .sdo_i(sdo), .sdo_o, .sdo_oe, .conv_data, .conv_valid,
      .drive_current_select(dcs), .internal_termination_enable(term), .output_disable(off),
      .lane_serialization_select(lss), .pattern_enable(pen), .pattern_high_bits(phi), .pattern_low_bits(plo),
      .drive_current_ua(), .drive_code_valid(), .two_lane(), .serial_bits(), .lane_mode_valid(),
      .lane_data(ld), .lane_valid(lv));
   task chk(input string n, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      h.xfer(1'b0, a, d, q);
      // Crossing needs three clocks before the next write
      repeat (6) @(posedge clock);
   endtask : wr
   task rd(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] q;
      h.xfer(1'b1, a, 8'hFF, q);
      chk("readback", {56'h0, e}, {56'h0, q});
   endtask : rd
   task send(input logic [55:0] d, input logic [55:0] e, input logic v);
      @(posedge clock);
      conv_valid <= 1'b1;
      conv_data <= d;
      @(posedge clock);
      conv_valid <= 1'b0;
      #1;
      chk("lane_data", {8'h0, e}, {8'h0, ld});
      chk("lane_valid", {63'h0, v}, {63'h0, lv});
   endtask : send
   task t_swreset;
      wr(7'h00, 8'h80);
      wr(7'h02, 8'h5A);
      wr(7'h03, 8'h7F);
      wr(7'h04, 8'hC3);
      // Writes must have landed, or the clear below proves nothing
      rd(7'h03, 8'h7F);
      wr(7'h00, 8'h80);
      rd(7'h02, 8'h00);
      rd(7'h03, 8'h00);
      rd(7'h04, 8'h00);
      chk("fields", 64'h0, {dcs, term, off, lss, pen, phi, plo});
      $display("t_swreset done");
   endtask : t_swreset
   task t_regs;
      wr(7'h02, 8'hA5);
      chk("mode", 64'hA5, {dcs, term, off, lss});
      rd(7'h02, 8'hA5);
      chk("mode_kept", 64'hA5, {dcs, term, off, lss});
      wr(7'h03, 8'hC5);
      wr(7'h04, 8'h3C);
      chk("pattern", 64'h453C, {pen, phi, plo});
      wr(7'h03, 8'h85);
      chk("pattern_b6", 64'h453C, {pen, phi, plo});
      rd(7'h04, 8'h3C);
      wr(7'h11, 8'hFF);
      rd(7'h11, 8'h00);
      $display("t_regs done");
   endtask : t_regs
   task t_modes;
      for (int i = 0; i < 16; i++) begin
         wr(7'h02, {i[2:0], i[3], 1'b0, i[2:0]});
         chk("mode_loop", {56'h0, i[2:0], i[3], 1'b0, i[2:0]}, {dcs, term, off, lss});
      end
      $display("t_modes done");
   endtask : t_modes
   task t_data;
      send(D, {4{14'h053C}}, 1'b1);
      // Bit 6 set must leave the pattern untouched
      wr(7'h03, 8'hC5);
      send(~D, {4{14'h053C}}, 1'b1);
      wr(7'h03, 8'h05);
      send(D, D, 1'b1);
      wr(7'h02, 8'h08);
      send(~D, ~D, 1'b0);
      $display("t_data done");
   endtask : t_data
   task t_hwreset;
      wr(7'h02, 8'hA5);
      @(posedge clock);
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      chk("fields_rst", 64'h0, {dcs, term, off, lss, pen, phi, plo});
      wr(7'h00, 8'h80);
      rd(7'h02, 8'h00);
      $display("t_hwreset done");
   endtask : t_hwreset
   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      t_swreset;
      t_regs;
      t_modes;
      t_data;
      t_hwreset;
      end_of_test;
   end
   initial begin
      #2000000;
      bad_count++;
      end_of_test;
   end
endmodule : tb
